// >>> asp_checker.sv
`timescale 1ns/1ps
// --------------
// port checks
// --------------
module asp_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd  = pready && !pwrite;
  wire bad = paddr >= 32'h0000_0020 || paddr[1:0] != 2'b00;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_answer;
    s_setup ##1 s_access |-> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("ready missing in access cycle");
  property p_single;
    pready |=> !pready;
  endproperty
  a_single: assert property (p_single) else $error("ready held over two cycles");
  property p_refuse;
    pready && bad |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
  property p_mapped;
    pready && !bad |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_upper;
    rd |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data above byte not zero");
  property p_ident;
    rd && paddr == 32'h0000_0008 |-> prdata[7:3] == 5'h00;
  endproperty
  a_ident: assert property (p_ident) else $error("ident upper bits set");
  property p_pend;
    rd && paddr == 32'h0000_0008 && $stable(irq_pending) && irq_pending == $past(irq_pending, 2)
      |-> prdata[0] == !irq_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("ident bit0 disagrees with pending");
  property p_lsr7;
    rd && paddr == 32'h0000_0014 |-> !prdata[7];
  endproperty
  a_lsr7: assert property (p_lsr7) else $error("line status bit7 set");
  property p_mcr;
    rd && paddr == 32'h0000_0010 |-> prdata[7:5] == 3'h0;
  endproperty
  a_mcr: assert property (p_mcr) else $error("modem ctrl upper bits set");
endmodule

bind asp_top asp_checker asp_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_pending(irq_pending)
);

// >>> asp_far.sv
`timescale 1ns/1ps
// --------------
// remote terminal
// --------------
module asp_far #(
  parameter int BIT = 16
) (
  input  wire        pclk,
  input  wire        line_in,
  input  wire  [5:0] fmt,
  output logic       line_out,
  output logic [7:0] got,
  output logic       got_ok,
  output logic       got_v
);
  // fmt is {stick, even, parity on, stop, word length}
  function automatic logic par(input [7:0] d);
    logic [7:0] m;
    m = 8'hff >> (3 - fmt[1:0]);
    return fmt[5] ? !fmt[4] : ^(d & m) ^ !fmt[4];
  endfunction
  task automatic bit_out(input logic b);
    line_out <= b;
    repeat (BIT) @(posedge pclk);
  endtask
  // line idles high, so a release shows as mark
  task automatic send(input [7:0] d, input bad_par, input bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 5 + fmt[1:0]; i++) bit_out(d[i]);
    if (fmt[3]) bit_out(par(d) ^ bad_par);
    bit_out(!bad_stop);
    bit_out(1'b1);
  endtask
  initial begin
    line_out = 1'b1;
    got_v = 1'b0;
  end
  always begin : rx
    logic [7:0] d;
    logic       ok;
    @(negedge line_in);
    d = 8'h00;
    repeat (BIT / 2) @(posedge pclk);
    ok = !line_in;
    for (int i = 0; i < 5 + fmt[1:0]; i++) begin
      repeat (BIT) @(posedge pclk);
      d[i] = line_in;
    end
    if (fmt[3]) begin
      repeat (BIT) @(posedge pclk);
      ok = ok && line_in == par(d);
    end
    repeat (BIT) @(posedge pclk);
    got <= d;
    got_ok <= ok && line_in;
    got_v <= 1'b1;
    @(posedge pclk);
    got_v <= 1'b0;
  end
endmodule

// >>> asp_regs.vh
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// ----------------------------------------
// register indices (byte address over four)
// ----------------------------------------
`define ASP_IDX_DATA        3'h0
`define ASP_IDX_IEN         3'h1
`define ASP_IDX_IID         3'h2
`define ASP_IDX_LCR         3'h3
`define ASP_IDX_MCR         3'h4
`define ASP_IDX_LSR         3'h5
`define ASP_IDX_MSR         3'h6
`define ASP_IDX_SCR         3'h7
`define ASP_ADDR_WIDTH      5
// ----------------------------------------
// line control fields
// ----------------------------------------
`define ASP_LCR_STOP        2
`define ASP_LCR_PAR_ON      3
`define ASP_LCR_EVEN        4
`define ASP_LCR_STICK       5
`define ASP_LCR_BREAK       6
`define ASP_LCR_DIVISOR_ACCESS_BIT        7
// ----------------------------------------
// modem control fields
// ----------------------------------------
`define ASP_MCR_LOOP        4
// ----------------------------------------
// reset values
// ----------------------------------------
`define ASP_DIV_RESET       16'h0001
`define ASP_IID_NONE        8'h01
// ----------------------------------------
// timing
// ----------------------------------------
`define ASP_OVERSAMPLE      16
`define ASP_MID_SAMPLE      4'h7
`endif

// >>> asp_rx.v
`timescale 1ns/1ps
`include "asp_regs.vh"
module asp_rx (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick,
  input  wire       serial_in,
  input  wire [1:0] word_len,
  input  wire       par_on,
  input  wire       even,
  input  wire       stick,
  output reg        done,
  output reg  [7:0] data,
  output reg        par_err,
  output reg        frm_err,
  output reg        brk
);
  // ----------------------------------------
  // sampler at mid bit on the 16x tick
  // ----------------------------------------
  localparam R_IDLE = 2'd0;
  localparam R_BITS = 2'd1;
  localparam R_STOP = 2'd2;
  reg [1:0] state;
  reg [3:0] sub;
  reg [3:0] cnt;
  reg [8:0] shreg;
  reg       zeros;
  wire [3:0] dbits = {2'b00, word_len} + 4'd5;
  wire [3:0] total = dbits + {3'b000, par_on};
  wire [7:0] mask  = 8'hff >> (3'd3 - {1'b0, word_len});
  // first data bit moved down to bit 0
  wire [8:0] aligned = shreg >> (4'd9 - total);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= R_IDLE;
      sub     <= 4'h0;
      cnt     <= 4'h0;
      shreg   <= 9'h000;
      zeros   <= 1'b1;
      done    <= 1'b0;
      data    <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      brk     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        case (state)
          R_IDLE: begin
            sub   <= 4'h0;
            zeros <= 1'b1;
            cnt   <= 4'h0;
            if (!serial_in)
              state <= R_BITS;
          end
          R_BITS: begin
            sub <= sub + 4'h1;
            if (sub == `ASP_MID_SAMPLE) begin
              if (cnt == 4'h0 && serial_in)
                state <= R_IDLE; // glitch, not a start bit
              else if (cnt != 4'h0) begin
                shreg <= {serial_in, shreg[8:1]};
                zeros <= zeros & ~serial_in;
              end
              if (cnt == total)
                state <= R_STOP;
              cnt <= cnt + 4'h1;
            end
          end
          R_STOP: begin
            sub <= sub + 4'h1;
            if (sub == `ASP_MID_SAMPLE) begin
              data    <= aligned[7:0] & mask;
              // last bit shifted in is the parity bit
              par_err <= par_on &
                         (shreg[8] != (stick ? ~even : ((^(aligned[7:0] & mask)) ^ ~even)));
              frm_err <= ~serial_in;
              brk     <= zeros & ~serial_in;
              done    <= 1'b1;
              state   <= R_IDLE;
            end
          end
          default: state <= R_IDLE;
        endcase
      end
    end
  end
endmodule

// >>> asp_top.v
`timescale 1ns/1ps
`include "asp_regs.vh"
// How it works
// - frame: start, five to eight data, optional parity, one/one-half/two stops
// - divisor 1 to 65535 divides pclk into a 16x tick driving transmitter
// - same 16x tick times receiver sampling
// - divisor bit clear: offset 0 is receive/transmit byte, offset 1 irq enable
// - divisor bit set: offsets 0 and 1 reach divisor low and high bytes
// - offsets 2 to 7 are ident, line ctrl, modem ctrl, statuses, scratch
// - irq enable bits 0-3 gate rx, tx empty, line, modem; host writes zero above
// - ident bit 0 low when pending, bits 1-2 id, bits 3-7 zero
// - line control bits 1:0 select five to eight data bits
// - line control bits 2-5: stops, parity on, even, stick
// - line control bit 6 forces break, bit 7 selects divisor bytes
// - modem control bits 0-3 drive outputs, bit 4 loopback; host zeros above
// - line status bits 0-4: ready, overrun, parity, framing, break
// - line status bit 5 holding empty, bit 6 shifter empty, bit 7 zero
// - modem status bits 0-3 flag input changes and ring trailing edge
// - modem status bits 4-7 show current input levels
// - divisor is high byte over low byte, sixteen bits
module asp_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        serial_in,
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ring_n,
  input  wire        dcd_n,
  output reg         serial_out,
  output reg         dtr_n,
  output reg         rts_n,
  output reg         out1_n,
  output reg         out2_n,
  output reg         irq_pending
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]  divisor_low;
  reg [7:0]  divisor_high;
  reg [7:0]  irq_enable;
  reg [7:0]  line_ctrl;
  reg [7:0]  modem_ctrl;
  reg [7:0]  scratch_byte;
  reg [7:0]  tx_holding;
  reg [7:0]  rx_buffer;
  reg        tx_holding_empty;
  reg        data_ready;
  reg        overrun;
  reg        parity_fault;
  reg        framing_fault;
  reg        line_break_seen;
  reg        clear_send_changed;
  reg        set_ready_changed;
  reg        ring_trailing_edge;
  reg        carrier_changed;
  reg [3:0]  modem_prev;
  reg [15:0] div_cnt;
  reg        tick;
  reg        tx_pending;
  wire       divisor_access_bit = line_ctrl[`ASP_LCR_DIVISOR_ACCESS_BIT];
  wire       loop = modem_ctrl[`ASP_MCR_LOOP];
  wire [15:0] divisor = {divisor_high, divisor_low};
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        access  = psel & penable & pready;
  wire        wr      = access & pwrite;
  wire        rd      = access & ~pwrite;
  wire [2:0]  idx     = paddr[4:2];
  wire        mapped  = (paddr[31:`ASP_ADDR_WIDTH] == 27'h0) & (paddr[1:0] == 2'b00);
  // ----------------------------------------
  // baud divider
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      // divisor 0 treated as 1; keeps the tick alive
      if (div_cnt + 16'h0001 >= divisor) begin
        div_cnt <= 16'h0000;
        tick    <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
        tick    <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // serial engines
  // ----------------------------------------
  wire       tx_line;
  wire       tx_busy;
  wire       tx_take;
  wire       rx_done;
  wire [7:0] rx_data;
  wire       rx_perr;
  wire       rx_ferr;
  wire       rx_brk;
  wire       tx_drive = tx_line & ~line_ctrl[`ASP_LCR_BREAK];
  wire       rx_line  = loop ? tx_drive : serial_in;
  asp_tx u_tx (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .load       (tx_pending & ~tx_busy),
    .data       (tx_holding),
    .word_len   (line_ctrl[1:0]),
    .two_stop   (line_ctrl[`ASP_LCR_STOP]),
    .par_on     (line_ctrl[`ASP_LCR_PAR_ON]),
    .even       (line_ctrl[`ASP_LCR_EVEN]),
    .stick      (line_ctrl[`ASP_LCR_STICK]),
    .serial_out (tx_line),
    .busy       (tx_busy),
    .take       (tx_take)
  );
  asp_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .serial_in (rx_line),
    .word_len  (line_ctrl[1:0]),
    .par_on    (line_ctrl[`ASP_LCR_PAR_ON]),
    .even      (line_ctrl[`ASP_LCR_EVEN]),
    .stick     (line_ctrl[`ASP_LCR_STICK]),
    .done      (rx_done),
    .data      (rx_data),
    .par_err   (rx_perr),
    .frm_err   (rx_ferr),
    .brk       (rx_brk)
  );
  // ----------------------------------------
  // modem inputs, looped or external
  // ----------------------------------------
  // order: cts, dsr, ring, carrier; active high internally
  wire [3:0] modem_now = loop ? {modem_ctrl[3], modem_ctrl[2], modem_ctrl[0], modem_ctrl[1]}
                              : {~dcd_n, ~ring_n, ~dsr_n, ~cts_n};
  // ----------------------------------------
  // interrupt identification
  // ----------------------------------------
  wire ev_line  = overrun | parity_fault | framing_fault | line_break_seen;
  wire ev_modem = clear_send_changed | set_ready_changed | ring_trailing_edge | carrier_changed;
  reg  [7:0] irq_ident;
  always @* begin
    // priority: line status, data, holding empty, modem
    if (irq_enable[2] & ev_line)
      irq_ident = 8'h06;
    else if (irq_enable[0] & data_ready)
      irq_ident = 8'h04;
    else if (irq_enable[1] & tx_holding_empty)
      irq_ident = 8'h02;
    else if (irq_enable[3] & ev_modem)
      irq_ident = 8'h00;
    else
      irq_ident = `ASP_IID_NONE;
  end
  wire [7:0] line_status = {1'b0, ~tx_busy & tx_holding_empty & ~tx_pending,
                            tx_holding_empty, line_break_seen, framing_fault,
                            parity_fault, overrun, data_ready};
  wire [7:0] modem_status = {modem_now, carrier_changed, ring_trailing_edge,
                             set_ready_changed, clear_send_changed};
  reg [7:0] rd_mux;
  always @* begin
    case (idx)
      `ASP_IDX_DATA: rd_mux = divisor_access_bit ? divisor_low : rx_buffer;
      `ASP_IDX_IEN:  rd_mux = divisor_access_bit ? divisor_high : irq_enable;
      `ASP_IDX_IID:  rd_mux = irq_ident;
      `ASP_IDX_LCR:  rd_mux = line_ctrl;
      `ASP_IDX_MCR:  rd_mux = modem_ctrl;
      `ASP_IDX_LSR:  rd_mux = line_status;
      `ASP_IDX_MSR:  rd_mux = modem_status;
      default:       rd_mux = scratch_byte;
    endcase
  end
  wire rd_rbr = rd & mapped & idx == `ASP_IDX_DATA & ~divisor_access_bit;
  wire rd_lsr = rd & mapped & idx == `ASP_IDX_LSR;
  wire rd_msr = rd & mapped & idx == `ASP_IDX_MSR;
  wire wr_ok  = wr & mapped;
  // ----------------------------------------
  // register state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready             <= 1'b0;
      prdata             <= 32'h0000_0000;
      pslverr            <= 1'b0;
      {divisor_high, divisor_low} <= `ASP_DIV_RESET;
      irq_enable         <= 8'h00;
      line_ctrl          <= 8'h00;
      modem_ctrl         <= 8'h00;
      scratch_byte       <= 8'h00;
      tx_holding         <= 8'h00;
      tx_pending         <= 1'b0;
      tx_holding_empty   <= 1'b1;
      rx_buffer          <= 8'h00;
      data_ready         <= 1'b0;
      overrun            <= 1'b0;
      parity_fault       <= 1'b0;
      framing_fault      <= 1'b0;
      line_break_seen    <= 1'b0;
      clear_send_changed <= 1'b0;
      set_ready_changed  <= 1'b0;
      ring_trailing_edge <= 1'b0;
      carrier_changed    <= 1'b0;
      modem_prev         <= 4'h0;
      serial_out         <= 1'b1;
      dtr_n              <= 1'b1;
      rts_n              <= 1'b1;
      out1_n             <= 1'b1;
      out2_n             <= 1'b1;
      irq_pending        <= 1'b0;
    end else begin
      // no wait state: answer in the access cycle after setup
      pready  <= psel & ~pready;
      pslverr <= psel & ~pready & ~mapped;
      if (psel & ~pready & ~pwrite)
        prdata <= mapped ? {24'h000000, rd_mux} : 32'h0000_0000;
      if (wr_ok) begin
        case (idx)
          `ASP_IDX_DATA: begin
            if (divisor_access_bit)
              divisor_low <= pwdata[7:0];
            else begin
              tx_holding <= pwdata[7:0];
              tx_pending <= 1'b1;
            end
          end
          `ASP_IDX_IEN: begin
            if (divisor_access_bit)
              divisor_high <= pwdata[7:0];
            else
              irq_enable <= {4'h0, pwdata[3:0]};
          end
          `ASP_IDX_LCR: line_ctrl    <= pwdata[7:0];
          `ASP_IDX_MCR: modem_ctrl   <= {3'b000, pwdata[4:0]};
          `ASP_IDX_SCR: scratch_byte <= pwdata[7:0];
          default: ;
        endcase
      end
      if (tx_take)
        tx_pending <= 1'b0;
      tx_holding_empty <= ~((wr_ok & idx == `ASP_IDX_DATA & ~divisor_access_bit) |
                           (tx_pending & ~tx_take));
      // hardware set beats the read clear
      if (rx_done) begin
        rx_buffer       <= rx_data;
        data_ready      <= 1'b1;
        overrun         <= data_ready & ~rd_rbr;
        parity_fault    <= rx_perr;
        framing_fault   <= rx_ferr;
        line_break_seen <= rx_brk;
      end else begin
        if (rd_rbr)
          data_ready <= 1'b0;
        if (rd_lsr) begin
          overrun         <= 1'b0;
          parity_fault    <= 1'b0;
          framing_fault   <= 1'b0;
          line_break_seen <= 1'b0;
        end
      end
      modem_prev         <= modem_now;
      clear_send_changed <= (modem_now[0] ^ modem_prev[0]) | (clear_send_changed & ~rd_msr);
      set_ready_changed  <= (modem_now[1] ^ modem_prev[1]) | (set_ready_changed & ~rd_msr);
      ring_trailing_edge <= (~modem_now[2] & modem_prev[2]) | (ring_trailing_edge & ~rd_msr);
      carrier_changed    <= (modem_now[3] ^ modem_prev[3]) | (carrier_changed & ~rd_msr);
      serial_out  <= loop ? 1'b1 : tx_drive;
      dtr_n       <= loop | ~modem_ctrl[0];
      rts_n       <= loop | ~modem_ctrl[1];
      out1_n      <= loop | ~modem_ctrl[2];
      out2_n      <= loop | ~modem_ctrl[3];
      irq_pending <= ~irq_ident[0];
    end
  end
endmodule

// >>> asp_tx.v
`timescale 1ns/1ps
`include "asp_regs.vh"
module asp_tx (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick,
  input  wire       load,
  input  wire [7:0] data,
  input  wire [1:0] word_len,
  input  wire       two_stop,
  input  wire       par_on,
  input  wire       even,
  input  wire       stick,
  output reg        serial_out,
  output reg        busy,
  output reg        take
);
  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_BITS = 2'd1;
  localparam S_STOP = 2'd2;
  reg [1:0]  state;
  reg [3:0]  sub;
  reg [10:0] shreg;
  reg [3:0]  nbits;
  reg [4:0]  stop_len;
  wire [3:0] dbits = {2'b00, word_len} + 4'd5;
  wire       dpar  = ^(data & (8'hff >> (3'd3 - {1'b0, word_len})));
  wire       pbit  = stick ? ~even : (dpar ^ even ^ 1'b1);
  wire [10:0] frame = {2'b11, pbit, data} << 0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      sub        <= 4'h0;
      shreg      <= 11'h7ff;
      nbits      <= 4'h0;
      stop_len   <= 5'd0;
      serial_out <= 1'b1;
      busy       <= 1'b0;
      take       <= 1'b0;
    end else begin
      take <= 1'b0;
      case (state)
        S_IDLE: begin
          if (load) begin
            busy  <= 1'b1;
            take  <= 1'b1;
            if (par_on)
              shreg <= ({3'b111, data} & ~(11'h7ff << dbits)) |
                       ({10'h000, pbit} << dbits) | (11'h7fe << dbits);
            else
              shreg <= ({3'b111, data} & ~(11'h7ff << dbits)) | (11'h7ff << dbits);
            nbits      <= dbits + {3'b000, par_on};
            // one and a half stops only at five bits
            // stop ticks minus one: 16, 24 or 32 ticks of mark
            stop_len   <= !two_stop ? 5'd15 : (word_len == 2'b00 ? 5'd23 : 5'd31);
            serial_out <= 1'b0;
            sub        <= 4'h0;
            state      <= S_BITS;
          end
        end
        S_BITS: begin
          if (tick) begin
            sub <= sub + 4'h1;
            if (sub == 4'hf) begin
              serial_out <= shreg[0];
              shreg      <= {1'b1, shreg[10:1]};
              nbits      <= nbits - 4'h1;
              if (nbits == 4'h0) begin
                serial_out <= 1'b1;
                state      <= S_STOP;
              end
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            if (stop_len == 5'd0) begin
              busy  <= 1'b0;
              state <= S_IDLE;
            end
            stop_len <= stop_len - 5'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
// --------------
// bench
// --------------
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, serial_in, serial_out, irq_pending, got_ok, got_v;
  logic  [3:0] mi;
  wire   [3:0] mo;
  logic  [5:0] fmt;
  wire   [7:0] got;
  logic [16:0] exp_q[$];
  logic  [8:0] tx_q[$];
  logic [16:0] e;
  int          miscompares, compares, cyc;
  integer      seed;
  logic  [7:0] r, m;
  logic  [3:0] p;
  asp_top asp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in(serial_in), .cts_n(mi[0]), .dsr_n(mi[1]),
    .ring_n(mi[2]), .dcd_n(mi[3]), .serial_out(serial_out), .dtr_n(mo[3]),
    .rts_n(mo[2]), .out1_n(mo[1]), .out2_n(mo[0]), .irq_pending(irq_pending));
  asp_far #(.BIT(16)) asp_far_inst (.pclk(pclk), .line_in(serial_out), .fmt(fmt),
    .line_out(serial_in), .got(got), .got_ok(got_ok), .got_v(got_v));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string n, input [8:0] x, input [8:0] s);
    compares++;
    if (x !== s) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input [7:0] a, input w, input [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input [7:0] a, input [7:0] x, input [7:0] k = 8'hff, input er = 1'b0);
    exp_q.push_back({er, k, x & k});
    apb(a, 1'b0, 8'h00);
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk("prdata", {e[16], e[7:0]}, {pslverr, prdata[7:0] & e[15:8]});
    end
    if (got_v === 1'b1)
      chk("tx frame", tx_q.pop_front(), {got_ok, got});
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {miscompares, compares, cyc} = '0;
    mi = 4'hf;
    fmt = 6'h03;
    seed = 32'ha746;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h14, 8'h60);
    rd(8'h08, 8'h01);
    wr(8'h0c, 8'h80);
    rd(8'h00, 8'h01);
    r = 8'($random(seed));
    wr(8'h00, r);
    wr(8'h04, ~r);
    rd(8'h00, r);
    rd(8'h04, ~r);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'h03);
    rd(8'h20, 8'h00, 8'hff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(8'h1c, r);
      rd(8'h1c, r);
    end
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      m = 8'hff >> (3 - i[1:0]);
      fmt <= {r[5:2], i[1:0]};
      wr(8'h0c, {2'b00, r[5:2], i[1:0]});
      asp_far_inst.send(r, 1'b0, 1'b0);
      rd(8'h00, r, m);
      tx_q.push_back({1'b1, r & m});
      wr(8'h00, r);
      while (tx_q.size() > 0) @(posedge pclk);
      repeat (40) @(posedge pclk);
      rd(8'h14, 8'h60);
    end
    $display("test formats done");
    fmt <= 6'h1b;
    wr(8'h0c, 8'h1b);
    asp_far_inst.send(8'h5a, 1'b1, 1'b0);
    rd(8'h14, 8'h65);
    rd(8'h14, 8'h61);
    rd(8'h00, 8'h5a);
    asp_far_inst.send(8'ha5, 1'b0, 1'b1);
    rd(8'h14, 8'h69);
    asp_far_inst.send(8'h11, 1'b0, 1'b0);
    rd(8'h14, 8'h63);
    rd(8'h00, 8'h00, 8'h00);
    rd(8'h14, 8'h60);
    tx_q.push_back(9'h000);
    wr(8'h0c, 8'h5b);
    repeat (250) @(posedge pclk);
    wr(8'h0c, 8'h1b);
    $display("test line errors done");
    wr(8'h04, 8'h02);
    repeat (2) @(posedge pclk);
    chk("irq", 9'h001, {8'h00, irq_pending});
    rd(8'h08, 8'h02);
    wr(8'h04, 8'h01);
    asp_far_inst.send(8'h3c, 1'b0, 1'b0);
    rd(8'h08, 8'h04);
    rd(8'h00, 8'h3c);
    wr(8'h04, 8'h00);
    rd(8'h08, 8'h01);
    wr(8'h10, 8'h0f);
    @(posedge pclk);
    chk("modem outs", 9'h000, {5'h00, mo});
    rd(8'h10, 8'h0f);
    rd(8'h18, 8'h00, 8'h00);
    p = 4'hf;
    for (int i = 0; i < 3; i++) begin
      r = 8'($random(seed));
      mi <= r[3:0];
      repeat (4) @(posedge pclk);
      rd(8'h18, {~r[3:0], p[3] ^ r[3], ~p[2] & r[2], p[1] ^ r[1], p[0] ^ r[0]});
      rd(8'h18, {~r[3:0], 4'h0});
      p = r[3:0];
    end
    wr(8'h10, 8'h1f);
    @(posedge pclk);
    chk("loop pins", 9'h01f, {4'h0, serial_out, mo});
    rd(8'h18, 8'hf0, 8'hf0);
    wr(8'h00, 8'h96);
    repeat (250) @(posedge pclk);
    rd(8'h00, 8'h96);
    chk("loop line", 9'h001, {8'h00, serial_out});
    wr(8'h10, 8'h00);
    $display("test modem done");
    chk("notes left", 9'h000, 9'(exp_q.size() + tx_q.size()));
    finish_test();
  end
endmodule
